// ### mfc_consts.svh
`ifndef MFC_CONSTS_SVH
`define MFC_CONSTS_SVH

// Sample width and timing
`define MFC_DW          16
`define MFC_CLK_NS      25
`define MFC_SAMPLE_NS   1000000
// Mains rejection windows in 1 ms samples (whole periods of the mains)
`define MFC_WIN_50HZ    8'h14
`define MFC_WIN_60HZ    8'h32
`define MFC_WIN_BOTH    8'h64
// Acquisition intervals in 1 ms samples
`define MFC_ACQ_1MS     8'h01
`define MFC_ACQ_10MS    8'h0a
`define MFC_ACQ_50MS    8'h32
`define MFC_ACQ_100MS   8'h64
// Averaging window and lag coefficient limits and resets
`define MFC_MA_MIN      7'h02
`define MFC_MA_MAX      7'h64
`define MFC_MA_RST      7'h64
`define MFC_LAG_MIN     7'h01
`define MFC_LAG_MAX     7'h64
`define MFC_LAG_RST     7'h01
// Register offsets
`define MFC_REG_CTRL    5'h00
`define MFC_REG_MALEN   5'h01
`define MFC_REG_LAGCOEF 5'h02
`define MFC_REG_INPUT   5'h03
`define MFC_REG_EXTOFS  5'h04
`define MFC_REG_RNGLO   5'h05
`define MFC_REG_RNGHI   5'h06
`define MFC_REG_STATUS  5'h07
`define MFC_REG_MEAS0   5'h08
// Control and input register fields
`define MFC_CTRL_MAINS  0
`define MFC_CTRL_SEL    1
`define MFC_CTRL_MA     3
`define MFC_CTRL_LAG    4
`define MFC_CTRL_IJC    5
`define MFC_CTRL_CHAIN  6
`define MFC_CTRL_ACQ    7
`define MFC_INPUT_TC    0
`define MFC_INPUT_TYPEB 1
// Range register resets
`define MFC_RNGLO_RST   16'h0000
`define MFC_RNGHI_RST   16'h7d00

`endif

// ### mfc_pkg.sv
`include "mfc_consts.svh"
package mfc_pkg;

	typedef enum logic [1:0] {
		MFC_HZ50   = 2'h0,
		MFC_HZ60   = 2'h1,
		MFC_HZBOTH = 2'h2
	} mfc_mains_t;

	typedef enum logic [1:0] {
		MFC_ACQ1   = 2'h0,
		MFC_ACQ10  = 2'h1,
		MFC_ACQ50  = 2'h2,
		MFC_ACQ100 = 2'h3
	} mfc_acq_t;

	// One channel from the converter front end
	typedef struct packed {
		logic signed [`MFC_DW-1:0] value;
		logic                      burnout;
		logic                      adc_err;
	} mfc_sample_t;

	// One filtered measured value
	typedef struct packed {
		logic signed [`MFC_DW-1:0] value;
		logic                      err;
	} mfc_meas_t;

endpackage

// ### mfc_filter_chain.sv
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "mfc_consts.svh"
module mfc_filter_chain
	import mfc_pkg::*;
#(
	parameter int NCH       = 4,
	parameter int MS_CYCLES = `MFC_SAMPLE_NS / `MFC_CLK_NS
)(
	input  logic                      sys_clk,
	input  logic                      resetn,
	input  logic [4:0]                reg_addr,
	input  logic [31:0]               reg_wdata,
	input  logic                      reg_wr,
	input  logic                      reg_rd,
	output logic [31:0]               reg_rdata,
	input  mfc_sample_t [NCH-1:0]     fe_sample,
	input  logic signed [`MFC_DW-1:0] cj_temp,
	input  logic                      sync_in,
	output logic                      sample_tick,
	output logic                      sync_out,
	output mfc_meas_t [NCH-1:0]       meas,
	output logic                      meas_valid
);
	localparam int DW  = `MFC_DW;
	localparam int SW  = DW + 8;
	localparam int MSW = $clog2(MS_CYCLES + 1);
	localparam int MAX = 100;

	logic                 mains_en_ff, ma_en_ff, lag_en_ff, ijc_en_ff, chain_en_ff;
	mfc_mains_t           mains_sel_ff;
	mfc_acq_t             acq_sel_ff;
	logic [6:0]           ma_len_ff, lag_coef_ff;
	logic                 is_tc_ff, type_b_ff, restart_ff;
	logic signed [DW-1:0] ext_ofs_ff, rng_lo_ff, rng_hi_ff;
	logic [31:0]          rdata_ff;
	logic [MSW-1:0]       ms_cnt_ff;
	logic                 tick_ff, sync_out_ff, nxt_tick;
	logic [7:0]           acq_cnt_ff, win_cnt_ff, acq_len, win_len;
	logic                 acq, acq_d1_ff, acq_d2_ff, acq_d3_ff, meas_valid_ff, win_end;
	logic signed [DW+1:0] lo_lim, hi_lim, span;
	logic signed [DW-1:0] adj;
	mfc_meas_t [NCH-1:0]  meas_ff;
	logic [NCH-1:0]       err_bits;

	// Register writes; out-of-range window or coefficient values are ignored
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			mains_en_ff  <= 1'b0;
			mains_sel_ff <= MFC_HZ50;
			ma_en_ff     <= 1'b0;
			lag_en_ff    <= 1'b0;
			ijc_en_ff    <= 1'b1;
			chain_en_ff  <= 1'b0;
			acq_sel_ff   <= MFC_ACQ1;
			ma_len_ff    <= `MFC_MA_RST;
			lag_coef_ff  <= `MFC_LAG_RST;
			is_tc_ff     <= 1'b0;
			type_b_ff    <= 1'b0;
			ext_ofs_ff   <= '0;
			rng_lo_ff    <= `MFC_RNGLO_RST;
			rng_hi_ff    <= `MFC_RNGHI_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`MFC_REG_CTRL: begin
					mains_en_ff <= reg_wdata[`MFC_CTRL_MAINS];
					if (reg_wdata[`MFC_CTRL_SEL+:2] != 2'h3) begin
						mains_sel_ff <= mfc_mains_t'(reg_wdata[`MFC_CTRL_SEL+:2]);
					end
					ma_en_ff    <= reg_wdata[`MFC_CTRL_MA];
					lag_en_ff   <= reg_wdata[`MFC_CTRL_LAG];
					ijc_en_ff   <= reg_wdata[`MFC_CTRL_IJC];
					chain_en_ff <= reg_wdata[`MFC_CTRL_CHAIN];
					acq_sel_ff  <= mfc_acq_t'(reg_wdata[`MFC_CTRL_ACQ+:2]);
				end
				`MFC_REG_MALEN: begin
					if (reg_wdata[6:0] >= `MFC_MA_MIN && reg_wdata[6:0] <= `MFC_MA_MAX) begin
						ma_len_ff <= reg_wdata[6:0];
					end
				end
				`MFC_REG_LAGCOEF: begin
					if (reg_wdata[6:0] >= `MFC_LAG_MIN && reg_wdata[6:0] <= `MFC_LAG_MAX) begin
						lag_coef_ff <= reg_wdata[6:0];
					end
				end
				`MFC_REG_INPUT: begin
					is_tc_ff  <= reg_wdata[`MFC_INPUT_TC];
					type_b_ff <= reg_wdata[`MFC_INPUT_TYPEB];
				end
				`MFC_REG_EXTOFS: ext_ofs_ff <= reg_wdata[DW-1:0];
				`MFC_REG_RNGLO:  rng_lo_ff  <= reg_wdata[DW-1:0];
				`MFC_REG_RNGHI:  rng_hi_ff  <= reg_wdata[DW-1:0];
				default: ;
			endcase
		end
	end

	// Any configuration write restarts the averaging and lag history (not the mains window sum) so sums stay consistent
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			restart_ff <= 1'b1;
		end else begin
			restart_ff <= reg_wr;
		end
	end

	// Register reads: data stand in the cycle after the strobe only
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rdata_ff <= '0;
		end else if (!reg_rd) begin
			rdata_ff <= '0;
		end else if (reg_addr >= `MFC_REG_MEAS0 && reg_addr < 5'(`MFC_REG_MEAS0 + NCH)) begin
			rdata_ff <= 32'(meas_ff[reg_addr - `MFC_REG_MEAS0].value);
		end else begin
			unique case (reg_addr)
				`MFC_REG_CTRL: rdata_ff <= {23'h0, acq_sel_ff, chain_en_ff, ijc_en_ff,
					lag_en_ff, ma_en_ff, mains_sel_ff, mains_en_ff};
				`MFC_REG_MALEN:   rdata_ff <= {25'h0, ma_len_ff};
				`MFC_REG_LAGCOEF: rdata_ff <= {25'h0, lag_coef_ff};
				`MFC_REG_INPUT:   rdata_ff <= {30'h0, type_b_ff, is_tc_ff};
				`MFC_REG_EXTOFS:  rdata_ff <= {16'h0, ext_ofs_ff};
				`MFC_REG_RNGLO:   rdata_ff <= {16'h0, rng_lo_ff};
				`MFC_REG_RNGHI:   rdata_ff <= {16'h0, rng_hi_ff};
				`MFC_REG_STATUS:  rdata_ff <= 32'(err_bits);
				default:          rdata_ff <= '0;
			endcase
		end
	end

	// 1 ms sample clock; a chain sync pulse realigns it, so units track within a cycle
	assign nxt_tick = (ms_cnt_ff == MSW'(MS_CYCLES - 1)) || (chain_en_ff && sync_in);
	always_ff @(posedge sys_clk) begin
		if (!resetn || nxt_tick) begin
			ms_cnt_ff <= '0;
		end else begin
			ms_cnt_ff <= ms_cnt_ff + MSW'(1);
		end
	end

	// One tick serves every channel, and is passed down the chain
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			tick_ff     <= 1'b0;
			sync_out_ff <= 1'b0;
		end else begin
			tick_ff     <= nxt_tick;
			sync_out_ff <= nxt_tick && chain_en_ff;
		end
	end

	// Interval and rejection window lengths in samples
	always_comb begin
		unique case (acq_sel_ff)
			MFC_ACQ1:  acq_len = `MFC_ACQ_1MS;
			MFC_ACQ10: acq_len = `MFC_ACQ_10MS;
			MFC_ACQ50: acq_len = `MFC_ACQ_50MS;
			default:   acq_len = `MFC_ACQ_100MS;
		endcase
		unique case (mains_sel_ff)
			MFC_HZ60:   win_len = `MFC_WIN_60HZ;
			MFC_HZBOTH: win_len = `MFC_WIN_BOTH;
			default:    win_len = `MFC_WIN_50HZ;
		endcase
	end

	assign acq     = tick_ff && (acq_cnt_ff >= acq_len - 8'h01);
	assign win_end = tick_ff && (win_cnt_ff >= win_len - 8'h01);

	// Interval and window counters, plus the stage-to-stage strobes
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			acq_cnt_ff <= '0;
			win_cnt_ff <= '0;
			acq_d1_ff  <= 1'b0;
			acq_d2_ff  <= 1'b0;
			acq_d3_ff  <= 1'b0;
			meas_valid_ff <= 1'b0;
		end else begin
			if (tick_ff) begin
				acq_cnt_ff <= acq ? 8'h00 : acq_cnt_ff + 8'h01;
				win_cnt_ff <= win_end ? 8'h00 : win_cnt_ff + 8'h01;
			end
			acq_d1_ff <= acq;
			acq_d2_ff <= acq_d1_ff;
			acq_d3_ff <= acq_d2_ff;
			meas_valid_ff <= acq_d3_ff;
		end
	end

	// Range-over limits at -5 and 105 percent of the input range
	assign span   = (DW+2)'(rng_hi_ff) - (DW+2)'(rng_lo_ff);
	assign lo_lim = (DW+2)'(rng_lo_ff) - span / (DW+2)'(20);
	assign hi_lim = (DW+2)'(rng_hi_ff) + span / (DW+2)'(20);
	// Junction correction for thermocouples: internal sensor, else external offset, or zero for type B
	assign adj = !is_tc_ff ? '0 : ijc_en_ff ? cj_temp : type_b_ff ? '0 : ext_ofs_ff;

	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch++) begin : g_ch
			logic                 bad, mbad_ff, merr_ff, aerr_ff, lerr_ff, seeded_ff;
			logic signed [DW-1:0] cval, mval_ff, aval_ff, y_ff, hist_ff [MAX];
			logic signed [SW-1:0] msum_ff, asum_ff, nsum;
			logic [6:0]           cnt_ff, wp_ff, old;
			logic signed [DW:0]   diff;

			assign bad  = fe_sample[ch].burnout || fe_sample[ch].adc_err
				|| (DW+2)'(fe_sample[ch].value) < lo_lim
				|| (DW+2)'(fe_sample[ch].value) > hi_lim;
			assign cval = fe_sample[ch].value + adj;
			assign err_bits[ch] = meas_ff[ch].err;

			// Mains rejection averages whole mains periods of 1 ms samples
			always_ff @(posedge sys_clk) begin
				if (!resetn) begin
					mval_ff <= '0;
					mbad_ff <= 1'b0;
					msum_ff <= '0;
					merr_ff <= 1'b0;
				end else if (tick_ff) begin
					if (!mains_en_ff || win_end) begin
						mval_ff <= mains_en_ff ? DW'((msum_ff + SW'(cval)) /
							$signed({1'b0, win_len})) : cval;
						mbad_ff <= (mains_en_ff && merr_ff) || bad;
						msum_ff <= '0;
						merr_ff <= 1'b0;
					end else begin
						msum_ff <= msum_ff + SW'(cval);
						merr_ff <= merr_ff || bad;
					end
				end
			end

			// Oldest entry of the averaging window in the circular history
			assign old  = (wp_ff >= ma_len_ff) ? wp_ff - ma_len_ff
				: wp_ff + 7'(MAX) - ma_len_ff;
			assign nsum = (cnt_ff < ma_len_ff) ? asum_ff + SW'(mval_ff)
				: asum_ff + SW'(mval_ff) - SW'(hist_ff[old]);

			// History is plain data and needs no reset
			always_ff @(posedge sys_clk) begin
				if (acq_d1_ff) begin
					hist_ff[wp_ff] <= mval_ff;
				end
			end

			// Moving average stage
			always_ff @(posedge sys_clk) begin
				if (!resetn || restart_ff) begin
					cnt_ff  <= '0;
					wp_ff   <= '0;
					asum_ff <= '0;
					aval_ff <= '0;
					aerr_ff <= 1'b0;
				end else if (acq_d1_ff) begin
					aerr_ff <= mbad_ff;
					if (!ma_en_ff || mbad_ff) begin
						aval_ff <= mval_ff;
						cnt_ff  <= '0;
						wp_ff   <= '0;
						asum_ff <= '0;
					end else begin
						wp_ff   <= (wp_ff == 7'(MAX - 1)) ? 7'h00 : wp_ff + 7'h01;
						asum_ff <= nsum;
						if (cnt_ff < ma_len_ff) begin
							cnt_ff  <= cnt_ff + 7'h01;
							aval_ff <= DW'(nsum / $signed({1'b0, cnt_ff + 7'h01}));
						end else begin
							aval_ff <= DW'(nsum / $signed({1'b0, ma_len_ff}));
						end
					end
				end
			end

			assign diff = (DW+1)'(aval_ff) - (DW+1)'(y_ff);

			// Lag stage; its time constant follows the interval it runs at
			always_ff @(posedge sys_clk) begin
				if (!resetn || restart_ff) begin
					y_ff      <= '0;
					seeded_ff <= 1'b0;
					lerr_ff   <= 1'b0;
				end else if (acq_d2_ff) begin
					lerr_ff <= aerr_ff;
					if (!lag_en_ff) begin
						y_ff      <= aval_ff;
						seeded_ff <= 1'b0;
					end else if (!aerr_ff) begin
						seeded_ff <= 1'b1;
						y_ff <= seeded_ff ? y_ff + DW'(diff / $signed({1'b0, lag_coef_ff}))
							: aval_ff;
					end
				end
			end

			// Result register drives the output directly
			always_ff @(posedge sys_clk) begin
				if (!resetn) begin
					meas_ff[ch] <= '0;
				end else if (acq_d3_ff) begin
					meas_ff[ch] <= '{value: y_ff, err: lerr_ff};
				end
			end

			a_ma_err_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
				acq_d1_ff && mbad_ff && !restart_ff |=> cnt_ff == 7'h00 && asum_ff == '0)
				else $error("averaging history kept after error sample");
			a_ma_bypass: assert property (@(posedge sys_clk) disable iff (!resetn)
				acq_d1_ff && !ma_en_ff && !restart_ff |=> aval_ff == $past(mval_ff))
				else $error("bypassed average differs from input");
			a_lag_hold_err: assert property (@(posedge sys_clk) disable iff (!resetn)
				acq_d2_ff && aerr_ff && lag_en_ff && !restart_ff |=> $stable(y_ff))
				else $error("lag state changed on error sample");
			a_ma_fill_cap: assert property (@(posedge sys_clk) disable iff (!resetn)
				cnt_ff <= ma_len_ff || restart_ff)
				else $error("averaging fill count exceeds window");
		end
	endgenerate

	assign reg_rdata   = rdata_ff;
	assign sample_tick = tick_ff;
	assign sync_out    = sync_out_ff;
	assign meas        = meas_ff;
	assign meas_valid  = meas_valid_ff;

	a_reset_defaults: assert property (@(posedge sys_clk)
		!resetn |=> !mains_en_ff && mains_sel_ff == MFC_HZ50 && !lag_en_ff && !ma_en_ff)
		else $error("filter enables not at reset defaults");
	a_len_in_range: assert property (@(posedge sys_clk) disable iff (!resetn)
		ma_len_ff >= `MFC_MA_MIN && ma_len_ff <= `MFC_MA_MAX)
		else $error("averaging window out of range");
	a_coef_in_range: assert property (@(posedge sys_clk) disable iff (!resetn)
		lag_coef_ff >= `MFC_LAG_MIN && lag_coef_ff <= `MFC_LAG_MAX)
		else $error("lag coefficient out of range");
	a_tick_spacing: assert property (@(posedge sys_clk) disable iff (!resetn)
		tick_ff && !chain_en_ff |=> !tick_ff [*8])
		else $error("sample ticks too close");
	a_stage_order: assert property (@(posedge sys_clk) disable iff (!resetn)
		acq |=> acq_d1_ff ##1 acq_d2_ff ##1 acq_d3_ff ##1 meas_valid)
		else $error("stages out of order");
	a_sync_chain: assert property (@(posedge sys_clk) disable iff (!resetn)
		sync_out |-> $past(chain_en_ff) && sample_tick)
		else $error("sync sent outside daisy chain");
endmodule

// ### mfc_fe_model.sv
`timescale 1ns/100ps
`include "mfc_consts.svh"
// Converter front end: shows one sample per tick, plus the upstream sync pulse
module mfc_fe_model
	import mfc_pkg::*;
#(
	parameter int NCH = 2
)(
	input  wire logic                      sys_clk,
	input  wire logic                      resetn,
	input  wire logic                      sample_tick,
	input  wire logic signed [`MFC_DW-1:0] base_val,
	input  wire logic signed [`MFC_DW-1:0] alt_step,
	input  wire logic signed [`MFC_DW-1:0] cj_val,
	input  wire logic                      bad_burn,
	input  wire logic                      bad_adc,
	input  wire logic                      sync_go,
	output mfc_sample_t [NCH-1:0]          fe_sample,
	output logic signed [`MFC_DW-1:0]      cj_temp,
	output logic                           sync_in
);
	logic                      phase_ff;
	logic signed [`MFC_DW-1:0] cur;
	// Alternate on every tick so a whole mains window averages to the midpoint
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			phase_ff <= 1'b0;
		end else if (sample_tick) begin
			phase_ff <= ~phase_ff;
		end
	end
	assign cur = phase_ff ? base_val + alt_step : base_val;
	// Outside a tick the converter output is stale, so show its inverse
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			fe_sample[c] = sample_tick ? {cur, bad_burn, bad_adc} : ~{cur, bad_burn, bad_adc};
		end
		cj_temp = sample_tick ? cj_val : ~cj_val;
	end
	// Upstream unit pulse, one cycle after the request
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			sync_in <= 1'b0;
		end else begin
			sync_in <= sync_go;
		end
	end
endmodule

// ### test_mfc_filter_chain.sv
`timescale 1ns/100ps
`include "mfc_consts.svh"
// Register and sample call sequences against the filter chain
module test_mfc_filter_chain
	import mfc_pkg::*;
;
	localparam int NCH = 2;
	localparam int MSC = 20;
	logic                  sys_clk, resetn, reg_wr, reg_rd, sample_tick, sync_in, sync_out;
	logic                  meas_valid, bad_burn, bad_adc, sync_go;
	logic [4:0]            reg_addr;
	logic [31:0]           reg_wdata, reg_rdata, rd;
	logic signed [15:0]    base_val, alt_step, cj_val, cj_temp, v1;
	mfc_sample_t [NCH-1:0] fe_sample;
	mfc_meas_t [NCH-1:0]   meas;
	int                    err_count, num_checks, gap;
	logic [4:0]            rst_a [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h1f};
	logic [31:0]           rst_v [8] = '{32'h20, 32'h64, 32'h01, 32'h0, 32'h0, 32'h0, 32'h7d00, 32'h0};
	int                    rv [5] = '{2100, 2101, -100, -101, 1234};
	int                    re [5] = '{0, 1, 0, 1, 0};
	int                    av [7] = '{30, 60, 91, 120, 5, 300, 600};
	int                    ax [7] = '{30, 45, 60, 90, 0, 300, 450};
	int                    lv [5] = '{400, 0, 0, 7, 0};
	int                    lx [5] = '{400, 300, 225, 0, 169};
	int                    jc [4] = '{32'h20, 32'h0, 32'h0, 32'h20};
	int                    ji [4] = '{1, 1, 3, 0};
	int                    jx [4] = '{1050, 1007, 1000, 1000};
	int                    tk [4] = '{`MFC_ACQ_1MS, `MFC_ACQ_10MS, `MFC_ACQ_50MS, `MFC_ACQ_100MS};
	int                    win [3] = '{`MFC_WIN_50HZ, `MFC_WIN_60HZ, `MFC_WIN_BOTH};

	mfc_filter_chain #(.NCH(NCH), .MS_CYCLES(MSC)) i_mfc_filter_chain (
		.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fe_sample(fe_sample),
		.cj_temp(cj_temp), .sync_in(sync_in), .sample_tick(sample_tick), .sync_out(sync_out),
		.meas(meas), .meas_valid(meas_valid));
	mfc_fe_model #(.NCH(NCH)) i_mfc_fe_model (
		.sys_clk(sys_clk), .resetn(resetn), .sample_tick(sample_tick), .base_val(base_val),
		.alt_step(alt_step), .cj_val(cj_val), .bad_burn(bad_burn), .bad_adc(bad_adc),
		.sync_go(sync_go), .fe_sample(fe_sample), .cj_temp(cj_temp), .sync_in(sync_in));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rdr(input logic [4:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask
	// Wait for the next tick or result, leaving the cycle count in gap
	task automatic wait_ev(input bit on_tick);
		gap = 0;
		do begin
			@(posedge sys_clk);
			#1 gap++;
		end while ((on_tick ? sample_tick : meas_valid) !== 1'b1 && gap < 3000);
		if (gap >= 3000) begin
			err_count++;
			$display("FAIL at %0t: no event", $time);
		end
	endtask
	// Offer one sample at the next tick and wait for its result
	task automatic feed(input int v, input logic bo, input logic ae);
		@(posedge sys_clk);
		base_val <= 16'(v);
		bad_burn <= bo;
		bad_adc  <= ae;
		wait_ev(0);
	endtask
	task automatic wrap_up();
		$display("Checks %0d, errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// 40 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Whole run is about 14k cycles; give it well over twice that
	initial begin
		#1000000;
		err_count++;
		$display("FAIL at %0t: watchdog expired", $time);
		wrap_up();
	end
	initial begin
		{resetn, reg_wr, reg_rd, reg_addr, reg_wdata, bad_burn, bad_adc, sync_go} = '0;
		base_val = 16'sd0;
		alt_step = 16'sd0;
		cj_val   = 16'sd50;
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rdr(rst_a[i]);
			check(rd, rst_v[i]);
		end
		// Lengths and coefficients outside their span are ignored
		wr(5'h01, 32'h1);
		wr(5'h01, 32'h65);
		wr(5'h02, 32'h0);
		wr(5'h02, 32'h65);
		rdr(5'h01);
		check(rd, 32'h64);
		rdr(5'h02);
		check(rd, 32'h01);
		// Span 0..2000 gives limits -100..2100; all filters bypassed
		wr(5'h06, 32'h7d0);
		wait_ev(0);
		for (int i = 0; i < 5; i++) begin
			feed(rv[i], 1'b0, 1'b0);
			check(meas[0].err, re[i]);
			check(meas[1].err, re[i]);
			if (re[i] == 0) check(32'(meas[0].value), rv[i]);
			rdr(5'h07);
			check(rd, 32'(re[i] * 3));
			rdr(5'h09);
			check(rd, 32'(rv[i]));
		end
		// Window of 3, an open sensor in mid-run empties it
		wr(5'h01, 32'h3);
		wr(5'h00, 32'h28);
		for (int i = 0; i < 7; i++) begin
			feed(av[i], i == 4, 1'b0);
			if (i == 4) check(meas[0].err, 1);
			else check(32'(meas[0].value), ax[i]);
		end
		// Lag with coefficient 4, a converter error must not move it
		wr(5'h02, 32'h4);
		wr(5'h00, 32'h30);
		for (int i = 0; i < 5; i++) begin
			feed(lv[i], 1'b0, i == 3);
			if (i == 3) check(meas[0].err, 1);
			else check(32'(meas[0].value), lx[i]);
		end
		// Internal, external and type B junction handling
		wr(5'h04, 32'h7);
		for (int i = 0; i < 4; i++) begin
			wr(5'h00, jc[i]);
			wr(5'h03, ji[i]);
			feed(1000, 1'b0, 1'b0);
			check(32'(meas[0].value), jx[i]);
		end
		// Result spacing for every acquisition interval
		for (int k = 0; k < 4; k++) begin
			wr(5'h00, 32'(k) << 7);
			wait_ev(0);
			wait_ev(0);
			check(gap, tk[k] * MSC);
			@(posedge sys_clk);
			#1 check(meas_valid, 0);
		end
		// Alternating input: passes raw when off, averages out in each mains window
		wr(5'h00, 32'h0);
		alt_step <= 16'sd100;
		feed(1000, 1'b0, 1'b0);
		v1 = meas[0].value;
		wait_ev(0);
		check(32'(v1) + 32'(meas[0].value), 2100);
		check(32'(v1 == 16'sd1050), 0);
		for (int s = 0; s < 3; s++) begin
			wr(5'h00, 32'h1 | (32'(s) << 1));
			repeat (2 * win[s] + 2) wait_ev(0);
			check(32'(meas[0].value), 1050);
		end
		wr(5'h00, 32'h7);
		rdr(5'h00);
		check(rd, 32'h5);
		// Upstream pulse realigns the tick only when chained
		alt_step <= 16'sd0;
		for (int c = 0; c < 2; c++) begin
			wr(5'h00, 32'(c) << 6);
			wait_ev(1);
			repeat (4) @(posedge sys_clk);
			sync_go <= 1'b1;
			@(posedge sys_clk);
			sync_go <= 1'b0;
			@(posedge sys_clk);
			#1 check(sample_tick, c);
			check(sync_out, c);
			if (c == 1) begin
				wait_ev(1);
				check(gap, MSC);
			end
		end
		wrap_up();
	end
endmodule
